// ===== hdl/plc_pkg.sv
// Purpose: Shared constants for the PLL lock detector and configuration block.
// Assumes: One system clock at 10 MHz; register port with one-cycle read latency.
// Notes:   Offsets are word indices on the plain register port.
package plc_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word indices)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_FILTER  = 4'h1;
  localparam logic [3:0] ADDR_PREDIV  = 4'h2;
  localparam logic [3:0] ADDR_FBDIV   = 4'h3;
  localparam logic [3:0] ADDR_OUTDIV0 = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h9;
  localparam logic [3:0] ADDR_INT_ST  = 4'ha;
  localparam logic [3:0] ADDR_INT_EN  = 4'hb;
  localparam logic [3:0] ADDR_INT_CLR = 4'hc;
  localparam int         NUM_OUTDIV   = 5;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_BYPASS_BIT = 1;
  localparam int CTRL_COARSE_BIT = 2;
  localparam int CTRL_QUAL_LSB   = 8;
  localparam int FILT_ICP_LSB    = 0;
  localparam int FILT_RES_LSB    = 4;
  localparam int INT_LOCK_BIT    = 0;
  localparam int INT_LOSS_BIT    = 1;
  localparam int INT_BADCFG_BIT  = 2;

  // ---------------------------------------------------------------------------
  // Ranges and reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ICP_CODES     = 4'he;
  localparam logic [2:0] RES_CODES     = 3'h6;
  localparam logic [5:0] DIV_MIN       = 6'h01;
  localparam logic [5:0] DIV_MAX       = 6'h20;
  localparam logic [6:0] VDIV_MIN      = 7'h02;
  localparam logic [6:0] VDIV_MAX      = 7'h40;
  localparam logic [8:0] QUAL_MIN      = 9'h010;
  localparam logic [8:0] QUAL_MAX      = 9'h100;
  localparam logic [8:0] QUAL_RST      = 9'h010;
  localparam logic [5:0] DIV_RST       = 6'h01;
  localparam logic [6:0] VDIV_RST      = 7'h02;
  localparam logic [3:0] ICP_RST       = 4'h0;
  localparam logic [2:0] RES_RST       = 3'h0;

  // Reference watchdog: system cycles without a divided reference edge.
  localparam int         REF_TIMEOUT_NS = 1000;
  localparam int         CLK_PERIOD_NS  = 100;
  localparam logic [7:0] REF_TIMEOUT_CYC = 8'(REF_TIMEOUT_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    PLC_UNLOCKED = 2'b00,
    PLC_QUALIFY  = 2'b01,
    PLC_LOCKED   = 2'b10
  } plc_state_t;

endpackage : plc_pkg

// ===== hdl/plc_edge_sync.sv
// Purpose: Two-stage synchroniser and rising-edge detector for a divided clock.
// Assumes: Input is asynchronous to clk_sys and slower than half its rate.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module plc_edge_sync
  import plc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      rise
);

  logic meta;
  logic sync;
  logic prev;

  // Edges alone are reported, so the duty cycle of the input never matters.
  assign rise = sync & ~prev;

  // Synchroniser and history stage.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (clk_en) begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

endmodule : plc_edge_sync

// ===== hdl/plc_lock_ctrl.sv
// Purpose: Lock detector and divider / loop-filter configuration of a clock PLL.
// Assumes: Divided reference and feedback clocks arrive as pins, asynchronous.
// Notes:   Configuration outputs are registered; illegal writes are refused.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module plc_lock_ctrl
  import plc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        ref_div_in,
  input  wire logic        fbk_div_in,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             lock_n,
  output logic             irq,
  output logic             bypass,
  output logic             coarse_skew,
  output logic [3:0]       pump_current,
  output logic [2:0]       loop_res,
  output logic [5:0]       prediv_ratio,
  output logic [5:0]       fbdiv_ratio,
  output logic [34:0]      outdiv_ratio
);

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic       freq_mode;
  logic [8:0] qual_count;
  logic [6:0] outdiv [NUM_OUTDIV];
  logic [2:0] int_st;
  logic [2:0] int_en;

  // Write decode and legality checks.
  wire        wr_ctrl   = reg_wr & (reg_addr == ADDR_CTRL);
  wire        wr_filter = reg_wr & (reg_addr == ADDR_FILTER);
  wire        wr_prediv = reg_wr & (reg_addr == ADDR_PREDIV);
  wire        wr_fbdiv  = reg_wr & (reg_addr == ADDR_FBDIV);
  wire        wr_int_en = reg_wr & (reg_addr == ADDR_INT_EN);
  wire        wr_clr    = reg_wr & (reg_addr == ADDR_INT_CLR);
  wire [8:0]  wq        = reg_wdata[CTRL_QUAL_LSB +: 9];
  wire        q_ok      = (wq >= QUAL_MIN) && (wq <= QUAL_MAX);
  wire [3:0]  w_icp     = reg_wdata[FILT_ICP_LSB +: 4];
  wire [2:0]  w_res     = reg_wdata[FILT_RES_LSB +: 3];
  wire        f_ok      = (w_icp < ICP_CODES) && (w_res < RES_CODES);
  wire [5:0]  wdiv      = reg_wdata[5:0];
  wire        d_ok      = (reg_wdata[31:6] == 26'h0) && (wdiv >= DIV_MIN) && (wdiv <= DIV_MAX);
  wire [6:0]  wvdiv     = reg_wdata[6:0];
  wire        v_ok      = (reg_wdata[31:7] == 25'h0) && !wvdiv[0]
                          && (wvdiv >= VDIV_MIN) && (wvdiv <= VDIV_MAX);
  wire        bad_wr    = (wr_ctrl & ~q_ok) | (wr_filter & ~f_ok)
                          | ((wr_prediv | wr_fbdiv) & ~d_ok);

  // Control register: mode, passthrough, coarse skew and qualification count.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      freq_mode   <= 1'b0;
      bypass      <= 1'b0;
      coarse_skew <= 1'b0;
      qual_count  <= QUAL_RST;
    end else if (clk_en && wr_ctrl && q_ok) begin
      freq_mode   <= reg_wdata[CTRL_MODE_BIT];
      bypass      <= reg_wdata[CTRL_BYPASS_BIT];
      coarse_skew <= reg_wdata[CTRL_COARSE_BIT];
      qual_count  <= wq;
    end
  end

  // Loop filter selection: code order follows rising current and resistance.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pump_current <= ICP_RST;
      loop_res     <= RES_RST;
    end else if (clk_en && wr_filter && f_ok) begin
      pump_current <= w_icp;
      loop_res     <= w_res;
    end
  end

  // Input prescaler and feedback divider ratios.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prediv_ratio <= DIV_RST;
      fbdiv_ratio  <= DIV_RST;
    end else if (clk_en && d_ok) begin
      if (wr_prediv) begin
        prediv_ratio <= wdiv;
      end
      if (wr_fbdiv) begin
        fbdiv_ratio <= wdiv;
      end
    end
  end

  // Five output dividers, each with its own address and check.
  logic [NUM_OUTDIV-1:0] bad_v;
  genvar g;
  generate
    for (g = 0; g < NUM_OUTDIV; g++) begin : g_vdiv
      wire wr_v = reg_wr & (reg_addr == ADDR_OUTDIV0 + 4'(g));
      assign bad_v[g] = wr_v & ~v_ok;
      assign outdiv_ratio[g*7 +: 7] = outdiv[g];
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          outdiv[g] <= VDIV_RST;
        end else if (clk_en && wr_v && v_ok) begin
          outdiv[g] <= wvdiv;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Lock detection
  // ---------------------------------------------------------------------------
  logic       ref_rise;
  logic       fbk_rise;
  logic       ref_seen;
  logic       fbk_seen;
  logic [7:0] ref_idle;
  logic [8:0] qual_cnt;
  plc_state_t state;
  plc_state_t next_state;

  plc_edge_sync u_ref_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (ref_div_in),
    .rise     (ref_rise)
  );

  plc_edge_sync u_fbk_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (fbk_div_in),
    .rise     (fbk_rise)
  );

  // One detection cycle ends at each reference edge; a cycle is frequency
  // matched when exactly one feedback edge fell inside it.
  wire phase_match = ref_rise & fbk_rise;
  wire pd_end      = ref_rise;
  wire fbk_count1  = (fbk_seen & ~fbk_rise) | (~fbk_seen & fbk_rise);
  wire freq_match  = pd_end & fbk_count1;
  wire freq_miss   = (pd_end & ~fbk_count1) | (fbk_rise & fbk_seen & ~ref_rise);
  // The watchdog makes the phase detector drop lock when the reference stops.
  wire ref_lost    = (ref_idle == REF_TIMEOUT_CYC);
  // A phase miss is a lone edge on either side, or a silent reference.
  wire phase_miss  = (ref_rise ^ fbk_rise) | ref_lost;
  wire cond_lost   = bypass | (freq_mode ? freq_miss : phase_miss);
  wire qual_done   = (qual_cnt + 9'h001 >= qual_count);

  // Frequency mode has no watchdog; a stopped reference drops lock at the second feedback edge after the last reference edge.
  always_comb begin
    next_state = state;
    unique case (state)
      PLC_UNLOCKED: begin
        if (!bypass && !freq_mode && phase_match) begin
          next_state = PLC_LOCKED;
        end else if (!bypass && freq_mode && freq_match) begin
          next_state = PLC_QUALIFY;
        end
      end
      PLC_QUALIFY: begin
        if (cond_lost || !freq_mode) begin
          next_state = PLC_UNLOCKED;
        end else if (freq_match && qual_done) begin
          next_state = PLC_LOCKED;
        end
      end
      PLC_LOCKED: begin
        if (cond_lost) begin
          next_state = PLC_UNLOCKED;
        end
      end
      default: next_state = PLC_UNLOCKED;
    endcase
  end

  // Detector state, edge bookkeeping and qualification counter.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state    <= PLC_UNLOCKED;
      ref_seen <= 1'b0;
      fbk_seen <= 1'b0;
      ref_idle <= 8'h00;
      qual_cnt <= 9'h000;
    end else if (clk_en) begin
      state    <= next_state;
      ref_seen <= ref_seen | ref_rise;
      fbk_seen <= pd_end ? 1'b0 : (fbk_seen | fbk_rise);
      ref_idle <= (ref_rise || ref_lost) ? 8'h00 : ref_idle + 8'h01;
      if (next_state != PLC_QUALIFY) begin
        qual_cnt <= 9'h000;
      end else if (freq_match) begin
        qual_cnt <= qual_cnt + 9'h001;
      end
    end
  end

  // Pin is low only in the locked state.
  assign lock_n = (state != PLC_LOCKED);

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  wire lock_gain = (state != PLC_LOCKED) & (next_state == PLC_LOCKED);
  wire lock_drop = (state == PLC_LOCKED) & (next_state != PLC_LOCKED);
  wire [2:0] int_set = {(bad_wr | (|bad_v)), lock_drop, lock_gain};

  // Set wins over a clear written in the same cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_st <= 3'h0;
      int_en <= 3'h0;
    end else if (clk_en) begin
      int_st <= (int_st & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | int_set;
      if (wr_int_en) begin
        int_en <= reg_wdata[2:0];
      end
    end
  end

  assign irq = |(int_st & int_en);

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  wire [31:0] outdiv_sel = (reg_addr >= ADDR_OUTDIV0 && reg_addr < ADDR_OUTDIV0 + 4'(NUM_OUTDIV))
                           ? {25'h0, outdiv[3'(reg_addr - ADDR_OUTDIV0)]} : 32'h0;
  wire [31:0] rd_mux =
      (reg_addr == ADDR_CTRL)   ? {15'h0, qual_count, 5'h0, coarse_skew, bypass, freq_mode} :
      (reg_addr == ADDR_FILTER) ? {25'h0, loop_res, pump_current} :
      (reg_addr == ADDR_PREDIV) ? {26'h0, prediv_ratio} :
      (reg_addr == ADDR_FBDIV)  ? {26'h0, fbdiv_ratio} :
      (reg_addr == ADDR_STATUS) ? {20'h0, ref_seen, qual_cnt, state} :
      (reg_addr == ADDR_INT_ST) ? {29'h0, int_st} :
      (reg_addr == ADDR_INT_EN) ? {29'h0, int_en} :
      outdiv_sel;

  // Read data stand one cycle after an enabled strobe and read as zero after other enabled cycles; low clk_en holds them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

endmodule : plc_lock_ctrl

// ===== tb/plc_lock_ctrl_sva.sv
// Purpose: Port-level checks for the lock detector and configuration block.
// Assumes: One clock domain; resetn is asynchronous and active low.
// Notes:   The mode bit is not a port, so the lock checks hold in both modes.
`timescale 1ns/1ps
module plc_lock_ctrl_sva
  import plc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        ref_div_in,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        lock_n,
  input wire logic        irq,
  input wire logic        bypass,
  input wire logic [3:0]  pump_current,
  input wire logic [2:0]  loop_res,
  input wire logic [5:0]  prediv_ratio,
  input wire logic [5:0]  fbdiv_ratio,
  input wire logic [34:0] outdiv_ratio
);
  logic        ref_q;
  logic [3:0]  since_ref;
  logic [31:0] wd_q;
  logic        ov_ok;
  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  // Cycles since the last reference rise; it saturates so that it never wraps.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_q     <= 1'b0;
      since_ref <= 4'hf;
      wd_q      <= 32'h0;
    end else begin
      ref_q     <= ref_div_in;
      since_ref <= (ref_div_in && !ref_q) ? 4'h0 : (since_ref == 4'hf) ? 4'hf : since_ref + 4'h1;
      wd_q      <= reg_wdata;
    end
  end
  // Every output divider field must hold an even ratio in range.
  always_comb begin
    ov_ok = 1'b1;
    for (int k = 0; k < NUM_OUTDIV; k++) begin
      if (outdiv_ratio[7*k +: 7] < VDIV_MIN || outdiv_ratio[7*k +: 7] > VDIV_MAX || outdiv_ratio[7*k]) begin
        ov_ok = 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_filt_ok;
    reg_wr && clk_en && reg_addr == ADDR_FILTER && reg_wdata[31:7] == 25'h0 && reg_wdata[3:0] < ICP_CODES
      && reg_wdata[6:4] < RES_CODES;
  endsequence
  sequence s_pre_bad;
    reg_wr && clk_en && reg_addr == ADDR_PREDIV && (reg_wdata > 32'h20 || reg_wdata == 32'h0);
  endsequence
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  reset_outs_a: assert property (disable iff (1'b0) !resetn |-> lock_n && !irq && reg_rdata == 32'h0)
    else $error("outputs not idle during reset");
  rdata_idle_a: assert property (!($past(reg_rd) && $past(clk_en)) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  bypass_unlock_a: assert property (bypass && $past(bypass) |-> lock_n)
    else $error("locked while in passthrough");
  lock_ref_a: assert property ($fell(lock_n) |-> since_ref <= 4'h6)
    else $error("lock gained away from a reference edge");
  cfg_range_a: assert property (pump_current < ICP_CODES && loop_res < RES_CODES)
    else $error("filter code out of range");
  div_range_a: assert property (prediv_ratio >= DIV_MIN && prediv_ratio <= DIV_MAX
    && fbdiv_ratio >= DIV_MIN && fbdiv_ratio <= DIV_MAX)
    else $error("input or feedback ratio out of range");
  outdiv_ok_a: assert property (ov_ok)
    else $error("output divider ratio illegal");
  filt_write_a: assert property (s_filt_ok |=> pump_current == wd_q[3:0] && loop_res == wd_q[6:4])
    else $error("legal filter write not applied");
  pre_keep_a: assert property (s_pre_bad |=> $stable(prediv_ratio))
    else $error("illegal prescaler write stored");
endmodule : plc_lock_ctrl_sva
bind plc_lock_ctrl plc_lock_ctrl_sva u_sva (.*);

// ===== tb/plc_clk_src.sv
// Purpose: Divided reference and feedback clock source for the lock detector.
// Assumes: Both clocks are stepped from clk_sys, a period of PER cycles, or 5 cycles for the feedback when fbk_fast is set.
// Notes:   The feedback keeps running when the reference stops, like a live oscillator.
`timescale 1ns/1ps
module plc_clk_src #(
  parameter int PER = 10
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ref_run,
  input  wire logic       fbk_fast,
  input  wire logic [3:0] fbk_skew,
  output logic            ref_div_in,
  output logic            fbk_div_in
);
  int ph;
  // A 30 percent high time shows that only edges matter to the detector.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph         <= 0;
      ref_div_in <= 1'b0;
      fbk_div_in <= 1'b0;
    end else begin
      ph         <= (ph == PER - 1) ? 0 : ph + 1;
      ref_div_in <= ref_run && ph < 3;
      fbk_div_in <= fbk_fast ? ((ph + PER - fbk_skew) % 5 < 2) : ((ph + PER - fbk_skew) % PER < 3);
    end
  end
endmodule : plc_clk_src

// ===== tb/plc_lock_ctrl_tb_top.sv
// Purpose: Self-checking bench for the lock detector and configuration block.
// Assumes: 10 MHz clk_sys, reference period of ten cycles from the clock source.
// Notes:   Lock timing windows allow for the synchroniser delay.
`timescale 1ns/1ps
module plc_lock_ctrl_tb_top
  import plc_pkg::*;
;
  logic        clk_sys;
  logic        resetn;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        lock_n;
  logic        irq;
  logic        bypass;
  logic        coarse_skew;
  logic [3:0]  pump_current;
  logic [2:0]  loop_res;
  logic [5:0]  prediv_ratio;
  logic [5:0]  fbdiv_ratio;
  logic [34:0] outdiv_ratio;
  logic        ref_div_in;
  logic        fbk_div_in;
  logic        ref_run;
  logic        fbk_fast;
  logic [3:0]  fbk_skew;
  logic [31:0] d;
  int          n;
  int          errors;
  int          num_checks;
  plc_lock_ctrl dut (.*);
  plc_clk_src u_src (.*);
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Every bus task starts and ends just after a rising edge, strobes lowered.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_lock(input logic lvl, input int lim);
    n = 0;
    while (lock_n !== lvl && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
  endtask : wait_lock
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    chk("lock_n", 1, lock_n);
    rd(ADDR_CTRL);
    chk("qual", QUAL_RST, d[16:8]);
    rd(ADDR_FILTER);
    chk("filter", 0, d);
    rd(ADDR_PREDIV);
    chk("prediv", DIV_RST, d);
    rd(ADDR_FBDIV);
    chk("fbdiv", DIV_RST, d);
    for (int k = 0; k < NUM_OUTDIV; k++) begin
      rd(ADDR_OUTDIV0 + 4'(k));
      chk("outdiv", VDIV_RST, d);
    end
    rd(4'hd);
    chk("unmapped", 0, d);
    $display("t_regs done");
  endtask : t_regs
  // A write while the clock enable is low must leave the filter register as it was.
  task automatic t_freeze();
    clk_en <= 1'b0;
    wr(ADDR_FILTER, 32'h25);
    chk("frozen filter", 0, {loop_res, pump_current});
    clk_en <= 1'b1;
    wr(ADDR_FILTER, 32'h25);
    chk("thawed filter", 32'h25, {loop_res, pump_current});
    $display("t_freeze done");
  endtask : t_freeze
  task automatic t_filter();
    for (int i = 0; i < 14; i++) begin
      wr(ADDR_FILTER, {25'h0, 3'(i % 6), 4'(i)});
      chk("pump_current", i, pump_current);
      chk("loop_res", i % 6, loop_res);
    end
    wr(ADDR_FILTER, 32'h0e);
    chk("pump_current", 13, pump_current);
    wr(ADDR_FILTER, 32'h60);
    chk("loop_res", 1, loop_res);
    rd(ADDR_INT_ST);
    chk("badcfg", 1, d[INT_BADCFG_BIT]);
    chk("irq", 0, irq);
    wr(ADDR_INT_EN, 32'h4);
    chk("irq", 1, irq);
    wr(ADDR_INT_CLR, 32'h4);
    chk("irq", 0, irq);
    wr(ADDR_FILTER, 32'h0); // Lowest pump current for a small product.
    $display("t_filter done");
  endtask : t_filter
  task automatic t_divs();
    wr(ADDR_PREDIV, 32'h20);
    wr(ADDR_PREDIV, 32'h21);
    chk("prediv", 32, prediv_ratio);
    wr(ADDR_FBDIV, 32'h20);
    wr(ADDR_FBDIV, 32'h0);
    chk("fbdiv", 32, fbdiv_ratio);
    for (int k = 0; k < NUM_OUTDIV; k++) begin
      wr(ADDR_OUTDIV0 + 4'(k), 32'(64 - 2 * k));
      wr(ADDR_OUTDIV0 + 4'(k), 32'h21);
    end
    for (int k = 0; k < NUM_OUTDIV; k++) begin
      chk("outdiv", 64 - 2 * k, outdiv_ratio[7*k +: 7]);
    end
    // Coarse skew makes software count the feedback division product twice for the filter.
    wr(ADDR_CTRL, 32'h1004);
    chk("coarse_skew", 1, coarse_skew);
    wr(ADDR_CTRL, 32'h10000);
    wr(ADDR_CTRL, 32'h0f00);
    rd(ADDR_CTRL);
    chk("qual", 256, d[16:8]);
    chk("coarse_skew", 0, coarse_skew);
    $display("t_divs done");
  endtask : t_divs
  task automatic t_phase();
    wr(ADDR_CTRL, 32'h1000);
    ref_run <= 1'b1;
    wait_lock(0, 40);
    chk("phase lock", 0, lock_n);
    rd(ADDR_STATUS);
    chk("status", {20'h0, 1'b1, 9'h000, PLC_LOCKED}, d);
    fbk_skew <= 4'h2;
    wait_lock(1, 20);
    chk("skew unlock", 1, lock_n);
    fbk_skew <= 4'h0;
    wait_lock(0, 40);
    ref_run <= 1'b0;
    wait_lock(1, 25);
    chk("ref loss", 1, lock_n);
    ref_run <= 1'b1;
    wait_lock(0, 40);
    wr(ADDR_CTRL, 32'h1002);
    repeat (30) @(posedge clk_sys);
    chk("passthrough", 1, lock_n);
    rd(ADDR_INT_ST);
    chk("lock events", 2'b11, d[1:0]);
    $display("t_phase done");
  endtask : t_phase
  task automatic t_freq();
    fbk_fast <= 1'b1;
    fbk_skew <= 4'h3;
    wr(ADDR_CTRL, 32'h1001);
    repeat (20) @(posedge clk_sys);
    chk("no lock", 1, lock_n);
    fbk_fast <= 1'b0;
    wait_lock(0, 300);
    chk("qualify", 1, n >= 140 && n <= 190);
    fbk_fast <= 1'b1;
    wait_lock(1, 15);
    chk("freq unlock", 1, lock_n);
    fbk_fast <= 1'b0;
    wait_lock(0, 300);
    chk("requalify", 1, n >= 140 && n <= 190);
    $display("t_freq done");
  endtask : t_freq
  // ---------------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ---------------------------------------------------------------------------
  // Free-running system clock of 100 ns.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Reset is held for sixteen cycles before the first request.
  initial begin
    // Reset falls after time zero, so every flop sees a real falling edge.
    {reg_addr, reg_wdata, reg_wr, reg_rd, ref_run, fbk_fast, fbk_skew} = '0;
    clk_en = 1'b1;
    resetn = 1'b1;
    #10;
    resetn = 1'b0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_freeze();
    t_filter();
    t_divs();
    t_phase();
    t_freq();
    results();
  end
  // The tests need under 1000 cycles, so this bound only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("watchdog expired");
    results();
  end
endmodule : plc_lock_ctrl_tb_top
